// ---- core/sdpr_pkg.sv ----
package sdpr_pkg;
  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 9;
  localparam int NARROW_W = 8;
  localparam int DEPTH = 131072;

  // ----------------------------------------
  // reset values and counter step
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CLEAR = 17'h00000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 17'h00001;
  localparam logic [DATA_W-1:0] DATA_RST = 9'h000;

  // output stage selection, live (unregistered) level of output_stage_select
  typedef enum logic {
    SDPR_FLOW,
    SDPR_PIPE
  } sdpr_stage_e;
endpackage : sdpr_pkg

// ---- core/sdpr_port.sv ----
`timescale 1ns/10ps
module sdpr_port
  import sdpr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic port_tick,
  input wire logic narrow,
  input wire logic port_enable_low,
  input wire logic port_enable_high,
  input wire logic write_not_read,
  input wire logic output_drive_enable,
  input wire logic output_stage_select,
  input wire logic [ADDR_W-1:0] address,
  input wire logic address_load_strobe,
  input wire logic count_advance_enable,
  input wire logic count_clear,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic [DATA_W-1:0] read_word,
  output logic [ADDR_W-1:0] addr_used,
  output logic write_strobe,
  output logic [DATA_W-1:0] write_word,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic standby
);

  // ----------------------------------------
  // address counter
  // ----------------------------------------
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic selected;
  logic [DATA_W-1:0] narrow_mask;

  assign selected = !port_enable_low && port_enable_high;
  assign narrow_mask = narrow ? {1'b0, {NARROW_W{1'b1}}} : {DATA_W{1'b1}};

  // counter next value; clear beats load beats hold/advance, enables not consulted
  always_comb begin
    if (!port_tick) begin
      addr_d = addr_q; // no port edge, counter rests
    end else if (!count_clear) begin
      addr_d = ADDR_CLEAR;
    end else if (!address_load_strobe) begin
      addr_d = address;
    end else if (count_advance_enable) begin
      addr_d = addr_q;
    end else begin
      addr_d = addr_q + ADDR_STEP;
    end
  end

  // the address used by this edge's access is the counter's new value
  assign addr_used = addr_d;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= ADDR_CLEAR;
    end else begin
      addr_q <= addr_d;
    end
  end

  // ----------------------------------------
  // write path, single cycle
  // ----------------------------------------
  assign write_strobe = port_tick && selected && !write_not_read;
  assign write_word = write_data & narrow_mask;

  // ----------------------------------------
  // read output stages
  // ----------------------------------------
  logic [DATA_W-1:0] flow_q;
  logic [DATA_W-1:0] flow_d;
  logic [DATA_W-1:0] pipe_q;
  logic [DATA_W-1:0] pipe_d;
  logic flow_drv_q;
  logic flow_drv_d;
  logic pipe_drv_q;
  logic pipe_drv_d;
  logic stby_q;
  logic stby_d;
  logic rd_now;

  assign rd_now = selected && write_not_read;

  // flow stage catches the array at the access edge, pipe stage one edge later
  always_comb begin
    flow_d = flow_q;
    pipe_d = pipe_q;
    flow_drv_d = flow_drv_q;
    pipe_drv_d = pipe_drv_q;
    stby_d = stby_q;
    if (port_tick) begin
      flow_drv_d = rd_now;
      if (rd_now) begin
        flow_d = read_word & narrow_mask;
      end
      pipe_d = flow_q;
      pipe_drv_d = flow_drv_q;
      stby_d = !selected;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flow_q <= DATA_RST;
      pipe_q <= DATA_RST;
      flow_drv_q <= 1'b0;
      pipe_drv_q <= 1'b0;
      stby_q <= 1'b1;
    end else begin
      flow_q <= flow_d;
      pipe_q <= pipe_d;
      flow_drv_q <= flow_drv_d;
      pipe_drv_q <= pipe_drv_d;
      stby_q <= stby_d;
    end
  end

  // mode pin is a static strap in practice; a change mid-burst re-times data
  assign data_out = (output_stage_select == SDPR_PIPE) ? pipe_q : flow_q;
  // output enable pin gates the drive with no clock in the path
  assign data_oe = ((output_stage_select == SDPR_PIPE) ? pipe_drv_q : flow_drv_q)
                   && !output_drive_enable;
  assign standby = stby_q;

endmodule : sdpr_port

// ---- core/sdpr_top.sv ----
`timescale 1ns/10ps
// What this block does
// - both ports reach any word of the shared array at the same time, each on its own edge.
// - the array is 128K words of 9 bits (8 in the narrow build) with a 17-bit address.
// - control, address and write data are captured on the port's rising edge, except output_drive_enable and output_stage_select.
// - each port picks flow-through or pipelined read output with its own select input.
// - pipelined read data appears one port edge later than flow-through data.
// - an edge seeing port_enable_low high or port_enable_high low deselects the port.
// - output_drive_enable high floats the data outputs at once, with no clock involved.
// - count_clear low sets the counter to 0 and that access uses address 0.
// - address_load_strobe low with clear high loads and uses the external address.
// - with clear, load and advance inputs all high the previous address is reused.
// - with count_advance_enable low and clear and load high the counter steps by one.
// - load and clear act regardless of the chip enables, write_not_read and the output controls; clear beats load.
// - the counter advances on count_advance_enable low even when the port is deselected.
// - a write completes within one port edge, timed inside the block.
module sdpr_top
  import sdpr_pkg::*;
#(
  parameter bit NARROW = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic a_port_tick,
  input wire logic a_port_enable_low,
  input wire logic a_port_enable_high,
  input wire logic a_write_not_read,
  input wire logic a_output_drive_enable,
  input wire logic a_output_stage_select,
  input wire logic [ADDR_W-1:0] a_address,
  input wire logic a_address_load_strobe,
  input wire logic a_count_advance_enable,
  input wire logic a_count_clear,
  input wire logic [DATA_W-1:0] a_data_in,
  output logic [DATA_W-1:0] a_data_out,
  output logic a_data_oe,
  output logic a_standby,
  input wire logic b_port_tick,
  input wire logic b_port_enable_low,
  input wire logic b_port_enable_high,
  input wire logic b_write_not_read,
  input wire logic b_output_drive_enable,
  input wire logic b_output_stage_select,
  input wire logic [ADDR_W-1:0] b_address,
  input wire logic b_address_load_strobe,
  input wire logic b_count_advance_enable,
  input wire logic b_count_clear,
  input wire logic [DATA_W-1:0] b_data_in,
  output logic [DATA_W-1:0] b_data_out,
  output logic b_data_oe,
  output logic b_standby
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  // release through two flops so no port sees a ragged deassertion
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // shared array
  // ----------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] a_addr;
  logic [ADDR_W-1:0] b_addr;
  logic a_wr;
  logic b_wr;
  logic [DATA_W-1:0] a_wword;
  logic [DATA_W-1:0] b_wword;
  logic [DATA_W-1:0] a_rword;
  logic [DATA_W-1:0] b_rword;

  // both ports read any word at once; a read beside a write sees the old word
  assign a_rword = mem[a_addr];
  assign b_rword = mem[b_addr];

  // array cells carry no reset; port b wins a same-word, same-edge write clash
  always_ff @(posedge clk_sys) begin
    if (a_wr) begin
      mem[a_addr] <= a_wword;
    end
    if (b_wr) begin
      mem[b_addr] <= b_wword;
    end
  end

  // ----------------------------------------
  // port control
  // ----------------------------------------
  sdpr_port u_port_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .port_tick(a_port_tick),
    .narrow(NARROW),
    .port_enable_low(a_port_enable_low),
    .port_enable_high(a_port_enable_high),
    .write_not_read(a_write_not_read),
    .output_drive_enable(a_output_drive_enable),
    .output_stage_select(a_output_stage_select),
    .address(a_address),
    .address_load_strobe(a_address_load_strobe),
    .count_advance_enable(a_count_advance_enable),
    .count_clear(a_count_clear),
    .write_data(a_data_in),
    .read_word(a_rword),
    .addr_used(a_addr),
    .write_strobe(a_wr),
    .write_word(a_wword),
    .data_out(a_data_out),
    .data_oe(a_data_oe),
    .standby(a_standby)
  );

  sdpr_port u_port_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .port_tick(b_port_tick),
    .narrow(NARROW),
    .port_enable_low(b_port_enable_low),
    .port_enable_high(b_port_enable_high),
    .write_not_read(b_write_not_read),
    .output_drive_enable(b_output_drive_enable),
    .output_stage_select(b_output_stage_select),
    .address(b_address),
    .address_load_strobe(b_address_load_strobe),
    .count_advance_enable(b_count_advance_enable),
    .count_clear(b_count_clear),
    .write_data(b_data_in),
    .read_word(b_rword),
    .addr_used(b_addr),
    .write_strobe(b_wr),
    .write_word(b_wword),
    .data_out(b_data_out),
    .data_oe(b_data_oe),
    .standby(b_standby)
  );

endmodule : sdpr_top

// ---- verification/sdpr_chk.sv ----
`timescale 1ns/10ps
// ----
// port output checks
// ----
module sdpr_chk
  import sdpr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic a_port_tick,
  input wire logic a_port_enable_low,
  input wire logic a_port_enable_high,
  input wire logic a_write_not_read,
  input wire logic a_output_drive_enable,
  input wire logic a_output_stage_select,
  input wire logic a_data_oe,
  input wire logic a_standby,
  input wire logic b_port_tick,
  input wire logic b_port_enable_low,
  input wire logic b_port_enable_high,
  input wire logic b_output_stage_select,
  input wire logic b_output_drive_enable,
  input wire logic b_data_oe
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // both chip enables in their active state
  wire sel_a = !a_port_enable_low && a_port_enable_high;
  wire rd_a = a_port_tick && sel_a && a_write_not_read;
  wire sel_b = !b_port_enable_low && b_port_enable_high;
  a_float_a: assert property (a_output_drive_enable |-> !a_data_oe) else $error("a drives");
  a_float_b: assert property (b_output_drive_enable |-> !b_data_oe) else $error("b drives");
  a_desel_stby: assert property (a_port_tick && !sel_a |=> a_standby) else $error("no stby");
  a_sel_wake: assert property (a_port_tick && sel_a |=> !a_standby) else $error("stby");
  a_desel_quiet: assert property (a_port_tick && !sel_a && !a_output_stage_select
    |=> !a_data_oe) else $error("desel oe");
  a_flow_read: assert property (rd_a && !a_output_stage_select && !a_output_drive_enable
    |=> a_data_oe || a_output_drive_enable) else $error("no flow data");
  a_write_quiet: assert property (a_port_tick && sel_a && !a_write_not_read
    && !a_output_stage_select |=> !a_data_oe) else $error("write oe");
  // the stage loaded by a deselected tick must still show after the next tick
  a_pipe_delay: assert property (b_port_tick && !sel_b && b_output_stage_select
    ##1 b_port_tick |=> !b_data_oe) else $error("pipe early");
endmodule : sdpr_chk

// ---- verification/sdpr_ctl.sv ----
`timescale 1ns/10ps
// ----
// controller model for one port
// ----
module sdpr_ctl
  import sdpr_pkg::*;
(
  input wire logic clk_sys,
  output logic tk,
  output logic e0_n,
  output logic e1,
  output logic wr,
  output logic [ADDR_W-1:0] ad,
  output logic ld_n,
  output logic cn_n,
  output logic cl_n,
  output logic [DATA_W-1:0] di
);
  // idle and deselected from time zero
  initial begin
    {tk, e0_n, e1, wr, ld_n, cn_n, cl_n} = 7'h2f;
    {ad, di} = '0;
  end
  // tick stays up so accesses can run back to back
  task automatic go(input logic s, w, l, n, c, input logic [16:0] a, input logic [8:0] d);
    tk <= 1'b1;
    {e0_n, e1} <= {!s, s};
    {wr, ld_n, cn_n, cl_n} <= {w, l, n, c};
    {ad, di} <= {a, d};
    @(posedge clk_sys);
  endtask : go
  // tick drops and address and data lines flip; the other controls keep their old value
  task automatic rest();
    tk <= 1'b0;
    {ad, di} <= ~{ad, di};
    @(posedge clk_sys);
  endtask : rest
endmodule : sdpr_ctl

// ---- verification/tb_sdpr_top.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_sdpr_top
  import sdpr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic a_port_tick, a_port_enable_low, a_port_enable_high, a_write_not_read, a_count_clear;
  logic a_address_load_strobe, a_count_advance_enable, a_data_oe, a_standby;
  logic b_port_tick, b_port_enable_low, b_port_enable_high, b_write_not_read, b_count_clear;
  logic b_address_load_strobe, b_count_advance_enable, b_data_oe, b_standby;
  logic a_output_drive_enable = 1'b0;
  logic b_output_drive_enable = 1'b0;
  logic a_output_stage_select = 1'b0;
  logic b_output_stage_select = 1'b1;
  logic [ADDR_W-1:0] a_address, b_address, ad;
  logic [DATA_W-1:0] a_data_in, a_data_out, b_data_in, b_data_out;
  logic [DATA_W-1:0] mem [int];
  logic [ADDR_W-1:0] ctr [2] = '{2{ADDR_CLEAR}};
  logic [31:0] lf = 32'h9397;
  int num_errors = 0;
  int total_checks = 0;
  always #12.5 clk_sys = !clk_sys;
  sdpr_top uut (.clk_sys, .resetn, .a_port_tick, .a_port_enable_low, .a_port_enable_high,
    .a_write_not_read, .a_output_drive_enable, .a_output_stage_select, .a_address,
    .a_address_load_strobe, .a_count_advance_enable, .a_count_clear, .a_data_in,
    .a_data_out, .a_data_oe, .a_standby, .b_port_tick, .b_port_enable_low,
    .b_port_enable_high, .b_write_not_read, .b_output_drive_enable, .b_output_stage_select,
    .b_address, .b_address_load_strobe, .b_count_advance_enable, .b_count_clear,
    .b_data_in, .b_data_out, .b_data_oe, .b_standby);
  sdpr_ctl ca (.clk_sys, .tk(a_port_tick), .e0_n(a_port_enable_low), .e1(a_port_enable_high),
    .wr(a_write_not_read), .ad(a_address), .ld_n(a_address_load_strobe),
    .cn_n(a_count_advance_enable), .cl_n(a_count_clear), .di(a_data_in));
  sdpr_ctl cb (.clk_sys, .tk(b_port_tick), .e0_n(b_port_enable_low), .e1(b_port_enable_high),
    .wr(b_write_not_read), .ad(b_address), .ld_n(b_address_load_strobe),
    .cn_n(b_count_advance_enable), .cl_n(b_count_clear), .di(b_data_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // counter priority: clear, then load, then hold, then step
  task automatic op(input int p, input logic s, w, l, n, c, input logic [16:0] a,
    input logic [8:0] d);
    ctr[p] = !c ? ADDR_CLEAR : !l ? a : n ? ctr[p] : ctr[p] + ADDR_STEP;
    if (s && !w) begin
      mem[ctr[p]] = d;
    end
    if (p == 0) begin
      ca.go(s, w, l, n, c, a, d);
    end
    else begin
      cb.go(s, w, l, n, c, a, d);
    end
  endtask : op
  // read data and drive flag, sampled once the edge has settled
  task automatic chk_rd(input int p, input logic [16:0] a);
    #1;
    `CHK(p ? {b_data_oe, b_data_out} : {a_data_oe, a_data_out}, {1'b1, mem[a]})
  endtask : chk_rd
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end
    else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // random writes, each read back on the very next tick
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      ad = (i == 0) ? 17'h1ffff : lf[16:0];
      op(i % 2, 1, 0, 0, 1, 1, ad, lf[25:17]);
      op(0, 1, 1, 0, 1, 1, ad, 9'h000);
      op(0, 1, 1, 1, 1, 1, ~ad, 9'h000);
      chk_rd(0, ad);
    end
    // stop both ports so no stale write keeps landing
    fork
      ca.rest();
      cb.rest();
    join
    // burst over the top of the array, then clear beats load
    op(0, 1, 0, 0, 1, 1, 17'h1fffe, 9'h1a5);
    for (int i = 0; i < 3; i++) begin
      op(0, 1, 0, 1, 0, 1, 17'h0, 9'h0f0 + i[8:0]);
    end
    op(0, 1, 1, 0, 0, 0, 17'h1fffe, 9'h000);
    chk_rd(0, 17'h00000);
    // a deselected tick still steps and loads but never writes
    op(0, 0, 1, 1, 0, 1, 17'h0, 9'h000);
    #1 `CHK({a_data_oe, a_standby}, 2'b01)
    op(0, 1, 1, 1, 1, 1, 17'h0, 9'h000);
    chk_rd(0, 17'h00001);
    op(0, 0, 0, 0, 1, 1, 17'h1fffe, 9'h000);
    op(0, 1, 1, 1, 1, 1, 17'h0, 9'h000);
    chk_rd(0, 17'h1fffe);
    ca.rest();
    // output enable held across an edge, then released again
    #3 a_output_drive_enable = 1'b1;
    #1 `CHK(a_data_oe, 1'b0)
    @(posedge clk_sys);
    a_output_drive_enable = 1'b0;
    #1 `CHK(a_data_oe, 1'b1)
    // same word on both ports at one tick, pipelined b one tick later
    fork
      op(0, 1, 1, 0, 1, 1, 17'h1fffe, 9'h000);
      op(1, 1, 1, 0, 1, 1, 17'h1fffe, 9'h000);
    join
    chk_rd(0, 17'h1fffe);
    `CHK(b_data_oe, 1'b0)
    fork
      ca.rest();
      op(1, 0, 1, 1, 1, 1, 17'h0, 9'h000);
    join
    chk_rd(1, 17'h1fffe);
    b_output_drive_enable = 1'b1;
    #1 `CHK(b_data_oe, 1'b0)
    op(1, 0, 1, 1, 1, 1, 17'h0, 9'h000);
    b_output_drive_enable = 1'b0;
    #1 `CHK({b_data_oe, b_standby}, 2'b01)
    cb.rest();
    repeat (2) @(posedge clk_sys);
    give_verdict();
  end
  // cut a hang short
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule : tb_sdpr_top
bind sdpr_top sdpr_chk chk (.clk_sys, .resetn, .a_port_tick, .a_port_enable_low,
  .a_port_enable_high, .a_write_not_read, .a_output_drive_enable, .a_output_stage_select,
  .a_data_oe, .a_standby, .b_port_tick, .b_port_enable_low, .b_port_enable_high,
  .b_output_stage_select, .b_output_drive_enable, .b_data_oe);
